// ==== design/sysmode_pkg.sv ====
// Package of constants and types for the system mode control register bank.
// How it works
// - Halt enters sleep when standby select is 0, software standby when 1.
// - Standby select stays 1 after interrupt wake; a software write of 0 or a reset clears it.
// - Settling codes 000..011 give 8192..65536 states, 10x gives 131072, 11x unused.
// - CPU and modules stay in standby for the whole settling time on wake.
// - Flash variant: code 100 gives 131072 states, code 101 gives 1024.
// - Reset source flag is read-only: external reset sets it, watchdog reset clears it.
// - Edge select 0 picks falling, 1 picks rising edge of the interrupt input.
// - Host port enable 0 disables, 1 enables the host interface in slave mode.
// - RAM enable gates on-chip RAM, resets to 1, kept through software standby.
// - Mode pin latch bits are read-only and capture the mode pins on each read.
// - Mode control bits 6,5,2 read 1 and bits 4,3 read 0, unwritable.
// - Bit 7 reads 1 unless flash model with expansion, where it starts from the high mode pin.
// - System control resets to 0 except reset source flag and RAM enable at 1.
// - Mode pins 01 expanded no ROM, 10 expanded with ROM, 11 single-chip, 00 invalid.
// - Software standby halts and initializes modules, keeps RAM, registers, port outputs.
package sysmode_pkg;

    // ****************************************************************
    // Register map.
    // ****************************************************************
    localparam logic [11:0] OFS_SYSTEM_CONTROL = 12'h000;
    localparam logic [11:0] OFS_MODE_CONTROL = 12'h004;
    localparam logic [11:0] OFS_STANDBY_CTRL = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int BIT_STANDBY_SELECT = 7;
    localparam int BIT_SETTLE_HI = 6;
    localparam int BIT_SETTLE_LO = 4;
    localparam int BIT_RESET_SOURCE = 3;
    localparam int BIT_EDGE_SELECT = 2;
    localparam int BIT_HOST_ENABLE = 1;
    localparam int BIT_RAM_ENABLE = 0;
    localparam int BIT_EXPANSION = 7;

    // ****************************************************************
    // Reset values and fixed bits.
    // ****************************************************************
    localparam logic [7:0] SYSCTL_RESET = 8'h09;
    localparam logic [7:0] MODE_FIXED_ONES = 8'h64;
    localparam logic [2:0] SETTLE_CODE_RESET = 3'h0;

    // ****************************************************************
    // Settling counts in states.
    // ****************************************************************
    localparam logic [17:0] SETTLE_8K = 18'h02000;
    localparam logic [17:0] SETTLE_16K = 18'h04000;
    localparam logic [17:0] SETTLE_32K = 18'h08000;
    localparam logic [17:0] SETTLE_64K = 18'h10000;
    localparam logic [17:0] SETTLE_128K = 18'h20000;
    localparam logic [17:0] SETTLE_1K = 18'h00400;

    // Power state of the chip.
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_STANDBY,
        PWR_SETTLE
    } pwr_state_t;

endpackage : sysmode_pkg

// ==== design/sysmode_regs.sv ====
// System control and mode control registers with power state sequencing.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module sysmode_regs #(
    parameter bit FLASH_MODEL = 1'b0,
    parameter bit HAS_EXPANSION = 1'b0
) (
    input wire logic I_CLK_SYS,
    input wire logic I_SYS_RST,
    input wire logic I_WDT_RESET,
    input wire logic [11:0] I_PADDR,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic O_PREADY,
    output logic [31:0] O_PRDATA,
    output logic O_PSLVERR,
    input wire logic I_HALT_EXEC,
    input wire logic I_WAKE_IRQ,
    input wire logic I_MODE_PIN_HIGH,
    input wire logic I_MODE_PIN_LOW,
    input wire logic I_NMI_PIN,
    output logic O_NMI_REQ,
    output logic O_HOST_PORT_ENABLE,
    output logic O_INTERNAL_RAM_ENABLE,
    output logic O_CPU_HALT,
    output logic O_MODULE_HALT,
    output logic O_MODULE_INIT,
    output logic O_EXPANDED_MODE,
    output logic O_ONCHIP_ROM_ENABLE,
    output logic O_MODE_INVALID
);
    import sysmode_pkg::*;

    // ****************************************************************
    // State record.
    // ****************************************************************
    typedef struct packed {
        logic standby_select;
        logic [2:0] settling_select;
        logic reset_source_flag;
        logic interrupt_edge_select;
        logic host_port_enable;
        logic internal_ram_enable;
        logic expansion_enable;
        logic mode_pin_latch_high;
        logic mode_pin_latch_low;
        logic exp_loaded;
        logic nmi_prev;
        logic nmi_req;
        pwr_state_t pwr;
        logic [17:0] settle_cnt;
        logic [31:0] rdata;
        logic slverr;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;

    // Decodes a settling code into a wait length; zero marks an unused code.
    function automatic logic [17:0] settle_len(input logic [2:0] code);
        case (code)
            3'h0: settle_len = SETTLE_8K;
            3'h1: settle_len = SETTLE_16K;
            3'h2: settle_len = SETTLE_32K;
            3'h3: settle_len = SETTLE_64K;
            3'h4: settle_len = SETTLE_128K;
            3'h5: settle_len = FLASH_MODEL ? SETTLE_1K : SETTLE_128K;
            default: settle_len = 18'h00000;
        endcase
    endfunction : settle_len

    // Assembles the system control byte.
    function automatic logic [7:0] sysctl_byte(input state_t s);
        sysctl_byte = {s.standby_select, s.settling_select, s.reset_source_flag,
                       s.interrupt_edge_select, s.host_port_enable, s.internal_ram_enable};
    endfunction : sysctl_byte

    logic setup_ph;
    logic access_ph;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] wbyte;
    logic [7:0] mode_byte;
    logic [17:0] len;
    logic nmi_edge;

    // Bus phases; the slave answers in the first access cycle.
    assign setup_ph = I_PSEL && !I_PENABLE;
    assign access_ph = I_PSEL && I_PENABLE;
    assign wr_fire = access_ph && I_PWRITE && I_PSTRB[0];
    assign rd_fire = setup_ph && !I_PWRITE;
    assign wbyte = I_PWDATA[7:0];

    // Next-state logic for registers, power sequencing and the bus answer.
    always_comb begin
        nxt_ff = cur_ff;
        len = settle_len(cur_ff.settling_select);
        nmi_edge = cur_ff.interrupt_edge_select ? (I_NMI_PIN && !cur_ff.nmi_prev)
                                                : (!I_NMI_PIN && cur_ff.nmi_prev);
        nxt_ff.nmi_prev = I_NMI_PIN;
        nxt_ff.nmi_req = nmi_edge;
        // Expansion bit starts from the high mode pin on the flash model, else from 1, once, just after reset.
        if (!cur_ff.exp_loaded) begin
            nxt_ff.exp_loaded = 1'b1;
            nxt_ff.expansion_enable = FLASH_MODEL ? I_MODE_PIN_HIGH : 1'b1;
        end
        // Writes; the reset source flag is not a write target.
        if (wr_fire && I_PADDR == OFS_SYSTEM_CONTROL) begin
            nxt_ff.standby_select = wbyte[BIT_STANDBY_SELECT];
            nxt_ff.settling_select = wbyte[BIT_SETTLE_HI:BIT_SETTLE_LO];
            nxt_ff.interrupt_edge_select = wbyte[BIT_EDGE_SELECT];
            nxt_ff.host_port_enable = wbyte[BIT_HOST_ENABLE];
            nxt_ff.internal_ram_enable = wbyte[BIT_RAM_ENABLE];
        end
        // Only the expansion bit of the mode register takes writes.
        if (wr_fire && I_PADDR == OFS_MODE_CONTROL && FLASH_MODEL && HAS_EXPANSION) begin
            nxt_ff.expansion_enable = wbyte[BIT_EXPANSION];
        end
        // Reading the mode register latches the pins in the setup cycle.
        if (rd_fire && I_PADDR == OFS_MODE_CONTROL) begin
            nxt_ff.mode_pin_latch_high = I_MODE_PIN_HIGH;
            nxt_ff.mode_pin_latch_low = I_MODE_PIN_LOW;
        end
        // Power state; standby keeps every register, RAM enable included.
        case (cur_ff.pwr)
            PWR_RUN: begin
                if (I_HALT_EXEC) begin
                    nxt_ff.pwr = cur_ff.standby_select ? PWR_STANDBY : PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                if (I_WAKE_IRQ || nmi_edge) begin
                    nxt_ff.pwr = PWR_RUN;
                end
            end
            PWR_STANDBY: begin
                if (I_WAKE_IRQ || nmi_edge) begin
                    nxt_ff.pwr = PWR_SETTLE;
                    nxt_ff.settle_cnt = (len == 18'h00000) ? SETTLE_128K : len;
                end
            end
            PWR_SETTLE: begin
                nxt_ff.settle_cnt = cur_ff.settle_cnt - 18'h00001;
                if (cur_ff.settle_cnt == 18'h00001) begin
                    nxt_ff.pwr = PWR_RUN;
                end
            end
            default: nxt_ff.pwr = PWR_RUN;
        endcase
        // Read data is prepared in the setup cycle and held in a flip-flop.
        mode_byte = {HAS_EXPANSION && FLASH_MODEL ? cur_ff.expansion_enable : 1'b1,
                     MODE_FIXED_ONES[6:2], I_MODE_PIN_HIGH, I_MODE_PIN_LOW};
        if (setup_ph) begin
            nxt_ff.slverr = 1'b0;
            nxt_ff.rdata = 32'h00000000;
            case (I_PADDR)
                OFS_SYSTEM_CONTROL: nxt_ff.rdata = {24'h000000, sysctl_byte(cur_ff)};
                OFS_MODE_CONTROL: nxt_ff.rdata = {24'h000000, mode_byte};
                OFS_STATUS: nxt_ff.rdata = {28'h0000000, O_MODE_INVALID, 1'b0, cur_ff.pwr};
                OFS_STANDBY_CTRL: nxt_ff.rdata = {14'h0000, len};
                default: nxt_ff.slverr = 1'b1;
            endcase
            if (I_PWRITE && I_PADDR != OFS_SYSTEM_CONTROL && I_PADDR != OFS_MODE_CONTROL) begin
                nxt_ff.slverr = 1'b1;
            end
        end
    end

    // Register the state; a watchdog reset clears the source flag.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST || I_WDT_RESET) begin
            cur_ff <= '0;
            cur_ff.settling_select <= SETTLE_CODE_RESET;
            cur_ff.reset_source_flag <= !I_WDT_RESET;
            cur_ff.internal_ram_enable <= SYSCTL_RESET[BIT_RAM_ENABLE];
            cur_ff.nmi_prev <= 1'b1;
            cur_ff.pwr <= PWR_RUN;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // Outputs.
    assign O_PREADY = 1'b1;
    assign O_PRDATA = cur_ff.rdata;
    assign O_PSLVERR = access_ph && cur_ff.slverr;
    assign O_NMI_REQ = cur_ff.nmi_req;
    assign O_HOST_PORT_ENABLE = cur_ff.host_port_enable;
    assign O_INTERNAL_RAM_ENABLE = cur_ff.internal_ram_enable;
    assign O_CPU_HALT = cur_ff.pwr != PWR_RUN;
    assign O_MODULE_HALT = cur_ff.pwr == PWR_STANDBY || cur_ff.pwr == PWR_SETTLE;
    assign O_MODULE_INIT = cur_ff.pwr == PWR_STANDBY;
    assign O_EXPANDED_MODE = I_MODE_PIN_HIGH ^ I_MODE_PIN_LOW;
    assign O_ONCHIP_ROM_ENABLE = I_MODE_PIN_HIGH;
    assign O_MODE_INVALID = !I_MODE_PIN_HIGH && !I_MODE_PIN_LOW;

endmodule : sysmode_regs
`default_nettype wire

// ==== sim/sysmode_regs_checker.sv ====
// Checker for the system mode register bank, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module sysmode_regs_checker (
    input wire logic I_CLK_SYS,
    input wire logic I_SYS_RST,
    input wire logic I_WDT_RESET,
    input wire logic [11:0] I_PADDR,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic I_HALT_EXEC,
    input wire logic I_WAKE_IRQ,
    input wire logic I_MODE_PIN_HIGH,
    input wire logic I_MODE_PIN_LOW,
    input wire logic I_NMI_PIN,
    input wire logic O_PREADY,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_NMI_REQ,
    input wire logic O_HOST_PORT_ENABLE,
    input wire logic O_INTERNAL_RAM_ENABLE,
    input wire logic O_CPU_HALT,
    input wire logic O_MODULE_HALT,
    input wire logic O_MODULE_INIT,
    input wire logic O_EXPANDED_MODE,
    input wire logic O_ONCHIP_ROM_ENABLE,
    input wire logic O_MODE_INVALID
);
    // ****************************************************************
    // Properties.
    // ****************************************************************
    // Both reset sources abort any check in flight.
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SYS_RST || I_WDT_RESET);
    sequence s_mode_rd;
        I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == 12'h004;
    endsequence
    sequence s_settle;
        O_CPU_HALT && O_MODULE_HALT && !O_MODULE_INIT;
    endsequence
    AST_READY: assert property (I_PSEL && I_PENABLE |-> O_PREADY)
        else $error("no ready in access phase");
    AST_RST_VAL: assert property ($fell(I_SYS_RST) |-> O_INTERNAL_RAM_ENABLE && !O_HOST_PORT_ENABLE)
        else $error("bad enables after reset");
    AST_HALT: assert property (I_HALT_EXEC && !O_CPU_HALT |=> O_CPU_HALT)
        else $error("halt ignored");
    AST_WAKE: assert property (O_CPU_HALT && !O_MODULE_HALT && I_WAKE_IRQ |=> !O_CPU_HALT)
        else $error("sleep not left");
    AST_SETTLE: assert property (O_MODULE_INIT && I_WAKE_IRQ |=> s_settle [*8])
        else $error("settling cut short");
    AST_MODE_RD: assert property (s_mode_rd |=> O_PRDATA == {26'h39, $past(I_MODE_PIN_HIGH), $past(I_MODE_PIN_LOW)})
        else $error("bad mode read");
    AST_NMI: assert property (O_NMI_REQ |-> $past(I_NMI_PIN) != $past(I_NMI_PIN, 2))
        else $error("request without edge");
    AST_DECODE: assert property (O_MODE_INVALID == !(I_MODE_PIN_HIGH || I_MODE_PIN_LOW)
        && O_ONCHIP_ROM_ENABLE == I_MODE_PIN_HIGH)
        else $error("bad mode decode");
endmodule : sysmode_regs_checker
bind sysmode_regs sysmode_regs_checker sysmode_regs_checker_i (.*);
`default_nettype wire

// ==== sim/sysmode_regs_test.sv ====
// Self-checking bench for the system mode register bank.
`timescale 1ns/1ns
`default_nettype none
module sysmode_regs_test;
    import sysmode_pkg::*;
    logic I_CLK_SYS, I_SYS_RST = 1'h1, I_WDT_RESET = 1'h0, I_PSEL = 1'h0, I_PENABLE = 1'h0;
    logic I_PWRITE = 1'h0, I_HALT_EXEC = 1'h0, I_WAKE_IRQ = 1'h0, I_NMI_PIN = 1'h1, e;
    logic I_MODE_PIN_HIGH = 1'h1, I_MODE_PIN_LOW = 1'h1, O_PREADY, O_PSLVERR, O_NMI_REQ;
    logic O_HOST_PORT_ENABLE, O_INTERNAL_RAM_ENABLE, O_CPU_HALT, O_MODULE_HALT, O_MODULE_INIT;
    logic O_EXPANDED_MODE, O_ONCHIP_ROM_ENABLE, O_MODE_INVALID;
    logic [11:0] I_PADDR = 12'h000;
    logic [31:0] I_PWDATA = 32'h0, O_PRDATA, r;
    logic [3:0] I_PSTRB = 4'hF;
    int n_fail = 0, total_checks = 0;
    // The flash variant gives the short 1024-state settle, keeping the run brief.
    sysmode_regs #(.FLASH_MODEL(1'h1), .HAS_EXPANSION(1'h0)) sysmode_regs_i (.*);
    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One transfer; the request stands until ready is seen at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge I_CLK_SYS);
        I_PSEL <= 1'h1;
        I_PWRITE <= w;
        I_PADDR <= a;
        I_PWDATA <= d;
        @(posedge I_CLK_SYS);
        I_PENABLE <= 1'h1;
        do begin
            @(posedge I_CLK_SYS);
            n++;
        end while (O_PREADY !== 1'h1 && n < 16);
        if (n >= 16) begin
            n_fail++;
            give_verdict();
        end
        r = O_PRDATA;
        e = O_PSLVERR;
        I_PSEL <= 1'h0;
        I_PENABLE <= 1'h0;
    endtask : apb
    // Pulses halt or wake for one cycle, then settles at the falling edge.
    task automatic hit(input logic wake);
        @(posedge I_CLK_SYS);
        I_WAKE_IRQ <= wake;
        I_HALT_EXEC <= !wake;
        @(posedge I_CLK_SYS);
        I_WAKE_IRQ <= 1'h0;
        I_HALT_EXEC <= 1'h0;
        @(negedge I_CLK_SYS);
    endtask : hit
    task automatic nmi(input logic v, input int exp);
        int h = 0;
        @(posedge I_CLK_SYS);
        I_NMI_PIN <= v;
        repeat (3) begin
            @(negedge I_CLK_SYS);
            if (O_NMI_REQ === 1'h1) h++;
        end
        chk(h, exp);
    endtask : nmi
    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_modes();
        for (int c = 0; c < 4; c++) begin
            {I_MODE_PIN_HIGH, I_MODE_PIN_LOW} <= c[1:0];
            apb(1'h0, 12'h004, 32'h0);
            chk(r, 32'hE4 | c);
            chk({O_EXPANDED_MODE, O_ONCHIP_ROM_ENABLE, O_MODE_INVALID},
                {c == 1 || c == 2, c[1], c == 0});
        end
    endtask : t_modes
    task automatic t_write();
        apb(1'h0, 12'h000, 32'h0);
        chk(r, 32'h09);
        apb(1'h1, 12'h000, 32'hF6);
        apb(1'h0, 12'h000, 32'h0);
        chk(r, 32'hFE);
        chk({O_HOST_PORT_ENABLE, O_INTERNAL_RAM_ENABLE}, 32'h2);
        apb(1'h1, 12'h004, 32'h1B);
        apb(1'h0, 12'h004, 32'h0);
        chk(r, 32'hE7);
        apb(1'h1, 12'h008, 32'h0);
        chk(e, 32'h1);
        apb(1'h0, 12'h010, 32'h0);
        chk(e, 32'h1);
    endtask : t_write
    task automatic t_power();
        int n = 0;
        apb(1'h1, 12'h000, 32'h01);
        hit(1'h0);
        chk({O_CPU_HALT, O_MODULE_HALT}, 32'h2);
        hit(1'h1);
        chk(O_CPU_HALT, 32'h0);
        // Short code set just before halting; the bench clock is too slow for 8 ms anyway.
        apb(1'h1, 12'h000, 32'hD1);
        hit(1'h0);
        chk({O_MODULE_INIT, O_INTERNAL_RAM_ENABLE}, 32'h3);
        hit(1'h1);
        while (O_CPU_HALT === 1'h1 && n < 2000) begin
            @(negedge I_CLK_SYS);
            n++;
        end
        chk(n, 32'd1024);
        apb(1'h0, 12'h000, 32'h0);
        chk(r, 32'hD9);
        // Right after the wake, software puts back a long settling code.
        apb(1'h1, 12'h000, 32'h41);
        apb(1'h0, 12'h000, 32'h0);
        chk(r, 32'h49);
        apb(1'h0, 12'h008, 32'h0);
        chk(r, 32'h00020000);
        apb(1'h0, 12'h00C, 32'h0);
        chk(r, 32'h0);
    endtask : t_power
    task automatic t_edges();
        apb(1'h1, 12'h000, 32'h01);
        nmi(1'h0, 1);
        nmi(1'h1, 0);
        apb(1'h1, 12'h000, 32'h05);
        nmi(1'h0, 0);
        nmi(1'h1, 1);
    endtask : t_edges
    // A watchdog reset clears the source flag; an external one sets it again.
    task automatic t_rst_src();
        @(posedge I_CLK_SYS);
        I_WDT_RESET <= 1'h1;
        @(posedge I_CLK_SYS);
        I_WDT_RESET <= 1'h0;
        apb(1'h0, 12'h000, 32'h0);
        chk(r, 32'h01);
        @(posedge I_CLK_SYS);
        I_SYS_RST <= 1'h1;
        @(posedge I_CLK_SYS);
        I_SYS_RST <= 1'h0;
        apb(1'h0, 12'h000, 32'h0);
        chk(r, 32'h09);
    endtask : t_rst_src
    initial begin
        I_CLK_SYS = 1'h0;
        forever #20 I_CLK_SYS = ~I_CLK_SYS;
    end
    // Main sequence.
    initial begin
        repeat (6) @(posedge I_CLK_SYS);
        I_SYS_RST <= 1'h0;
        t_write();
        t_modes();
        t_power();
        t_edges();
        t_rst_src();
        give_verdict();
    end
endmodule : sysmode_regs_test
`default_nettype wire
